// ===== design/cpw_pkg.sv
package cpw_pkg;

   // -----------------------------------------------------------------
   // Register offsets (byte addresses)
   // -----------------------------------------------------------------
   localparam logic [7:0] OFF_MODE = 8'h00;
   localparam logic [7:0] OFF_VALUE = 8'h04;
   localparam logic [7:0] OFF_T2CTRL = 8'h08;
   localparam logic [7:0] OFF_PERIOD = 8'h0c;
   localparam logic [7:0] OFF_T2CNT = 8'h10;
   localparam logic [7:0] OFF_STATUS = 8'h14;
   localparam logic [7:0] OFF_IRQEN = 8'h18;

   // -----------------------------------------------------------------
   // Field positions
   // -----------------------------------------------------------------
   localparam int MODE_LSB = 0;
   localparam int DLSB_LSB = 4;
   localparam int PS_LSB = 0;
   localparam int T2ON_BIT = 2;
   localparam int POST_LSB = 3;
   localparam int EVT_BIT = 0;
   localparam int T2F_BIT = 1;
   localparam int PIN_BIT = 2;
   localparam int IE_BIT = 0;

   // -----------------------------------------------------------------
   // Reset values
   // -----------------------------------------------------------------
   localparam logic [7:0] PERIOD_RST = 8'hff;
   localparam logic [5:0] MODE_REG_RST = 6'h00;
   localparam logic [6:0] T2CTRL_RST = 7'h00;

   // -----------------------------------------------------------------
   // Timing: oscillator periods per timer2 tick at each prescale
   // -----------------------------------------------------------------
   localparam int QUARTERS = 4;
   localparam logic [1:0] PS_DIV1 = 2'b00;
   localparam logic [1:0] PS_DIV4 = 2'b01;
   localparam logic [5:0] PRE_LAST_1 = 6'(QUARTERS * 1 - 1);
   localparam logic [5:0] PRE_LAST_4 = 6'(QUARTERS * 4 - 1);
   localparam logic [5:0] PRE_LAST_16 = 6'(QUARTERS * 16 - 1);

   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;

   // Unit operating modes.
   typedef enum logic [3:0] {
      MODE_OFF = 4'b0000,
      MODE_CMP_HIGH = 4'b1000,
      MODE_CMP_LOW = 4'b1001,
      MODE_CMP_SOFT = 4'b1010,
      MODE_CMP_SPECIAL = 4'b1011,
      MODE_PWM = 4'b1100
   } cpw_mode_e;

endpackage

// ===== design/cpw_unit.sv
`timescale 1ns/1ps
// Notes on behaviour
// - Compare mode checks value against timer1 continuously.
// - Match drives pin high, low, or unchanged.
// - Match raises interrupt with the pin action.
// - Software-interrupt setting leaves pin, raises interrupt.
// - Special event clears timer1, starts conversion.
// - PWM period is (period+1) x 4 x prescale.
// - Period match clears timer2, sets pin unless the new duty is zero, reloads duty.
// - Postscaler never changes the PWM period.
// - Duty is 10 bits: byte plus two bits.
// - High time is duty x oscillator x prescale.
// - Duty writes apply at period end; high read-only in PWM.
// - Duty double-buffered with high byte and latch.
// - Pin clears when duty equals extended timer2.
// - Duty beyond period gives constant high output.
// - Zero mode write forces the output pin low.
// - Prescaler divides by 1, 4 or 16.
// - Timer2 counts to period then restarts.
// - Event flag is sticky until software clears.
// - Two-bit field selects the prescale factor.
module cpw_unit (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] timer1_count,
   output logic shared_output_pin,
   output logic timer1_clear,
   output logic adc_start,
   output logic unit_irq
);

   // -----------------------------------------------------------------
   // Register state
   // -----------------------------------------------------------------
   logic [3:0] mode_q;
   logic [1:0] dlsb_q;
   logic [7:0] duty_low_buffer;
   logic [7:0] duty_active_high;
   logic [1:0] duty_latch_q;
   logic [6:0] timer2_control;
   logic [7:0] period_register;
   logic [7:0] timer2_count;
   logic [5:0] pre_q;
   logic [3:0] post_q;
   logic unit_event_flag;
   logic t2_flag_q;
   logic irq_en_q;
   logic cmp_eq_q;

   logic aw_have_q;
   logic w_have_q;
   logic [7:0] awaddr_q;
   logic [31:0] wdata_q;
   logic [3:0] wstrb_q;

   // -----------------------------------------------------------------
   // Write decode
   // -----------------------------------------------------------------
   logic wr_en;
   logic [31:0] wmask;
   logic [31:0] wval;
   logic wr_mode;
   logic wr_value;
   logic wr_t2ctrl;
   logic wr_period;
   logic wr_t2cnt;
   logic wr_status;
   logic wr_irqen;
   logic wr_ok;

   assign wr_en = aw_have_q && w_have_q && !s_axi_bvalid;
   assign wmask = {{8{wstrb_q[3]}}, {8{wstrb_q[2]}}, {8{wstrb_q[1]}}, {8{wstrb_q[0]}}};
   assign wval = wdata_q & wmask;
   assign wr_mode = wr_en && awaddr_q == cpw_pkg::OFF_MODE;
   assign wr_value = wr_en && awaddr_q == cpw_pkg::OFF_VALUE;
   assign wr_t2ctrl = wr_en && awaddr_q == cpw_pkg::OFF_T2CTRL;
   assign wr_period = wr_en && awaddr_q == cpw_pkg::OFF_PERIOD;
   assign wr_t2cnt = wr_en && awaddr_q == cpw_pkg::OFF_T2CNT;
   assign wr_status = wr_en && awaddr_q == cpw_pkg::OFF_STATUS;
   assign wr_irqen = wr_en && awaddr_q == cpw_pkg::OFF_IRQEN;
   assign wr_ok = wr_mode || wr_value || wr_t2ctrl || wr_period || wr_t2cnt || wr_status
      || wr_irqen;

   // Merged mode register after a write; masked lanes keep old bits.
   logic [5:0] mode_new;
   assign mode_new = (wval[5:0] | ({dlsb_q, mode_q} & ~wmask[5:0]));

   // -----------------------------------------------------------------
   // Timer2 time base
   // -----------------------------------------------------------------
   logic [1:0] ps;
   logic t2_on;
   logic [3:0] post_sel;
   logic [5:0] pre_last;
   logic [1:0] low2;
   logic quarter_end;
   logic [9:0] ext_next;
   logic tick;
   logic period_hit;
   logic is_pwm;
   logic is_cmp;
   logic [9:0] duty_next;

   assign ps = timer2_control[cpw_pkg::PS_LSB +: 2];
   assign t2_on = timer2_control[cpw_pkg::T2ON_BIT];
   assign post_sel = timer2_control[cpw_pkg::POST_LSB +: 4];
   assign is_pwm = mode_q == cpw_pkg::MODE_PWM;
   assign is_cmp = mode_q == cpw_pkg::MODE_CMP_HIGH || mode_q == cpw_pkg::MODE_CMP_LOW
      || mode_q == cpw_pkg::MODE_CMP_SOFT || mode_q == cpw_pkg::MODE_CMP_SPECIAL;
   assign duty_next = {duty_low_buffer, dlsb_q};

   always_comb begin
      case (ps)
         cpw_pkg::PS_DIV1: begin
            pre_last = cpw_pkg::PRE_LAST_1;
            low2 = pre_q[1:0];
            quarter_end = 1'b1;
         end
         cpw_pkg::PS_DIV4: begin
            pre_last = cpw_pkg::PRE_LAST_4;
            low2 = pre_q[3:2];
            quarter_end = pre_q[1:0] == 2'h3;
         end
         default: begin
            pre_last = cpw_pkg::PRE_LAST_16;
            low2 = pre_q[5:4];
            quarter_end = pre_q[3:0] == 4'hf;
         end
      endcase
   end

   assign tick = t2_on && pre_q == pre_last;
   assign period_hit = tick && timer2_count == period_register;

   // The pin register is compared one clock ahead, so it falls as the extended count reaches the duty.
   // This keeps the high time at exactly duty x prescale clocks.
   assign ext_next = {timer2_count, low2} + 10'd1;

   // A write to the count or control register restarts the prescaler.
   always_ff @(posedge aclk) begin
      if (!aresetn || wr_t2ctrl || wr_t2cnt) begin
         pre_q <= '0;
      end else if (t2_on) begin
         pre_q <= tick ? '0 : pre_q + 6'd1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer2_count <= '0;
      end else if (wr_t2cnt) begin
         timer2_count <= wval[7:0];
      end else if (period_hit) begin
         timer2_count <= '0;
      end else if (tick) begin
         timer2_count <= timer2_count + 8'd1;
      end
   end

   // Postscaler only feeds its own flag, never the period.
   always_ff @(posedge aclk) begin
      if (!aresetn || wr_t2ctrl || wr_t2cnt) begin
         post_q <= '0;
      end else if (period_hit) begin
         post_q <= (post_q == post_sel) ? 4'h0 : post_q + 4'h1;
      end
   end

   // -----------------------------------------------------------------
   // Control registers
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         {dlsb_q, mode_q} <= cpw_pkg::MODE_REG_RST;
         timer2_control <= cpw_pkg::T2CTRL_RST;
         period_register <= cpw_pkg::PERIOD_RST;
         irq_en_q <= 1'b0;
         duty_low_buffer <= '0;
      end else begin
         if (wr_mode) begin
            {dlsb_q, mode_q} <= mode_new;
         end
         if (wr_t2ctrl) begin
            timer2_control <= wval[6:0] | (timer2_control & ~wmask[6:0]);
         end
         if (wr_period) begin
            period_register <= wval[7:0] | (period_register & ~wmask[7:0]);
         end
         if (wr_irqen) begin
            irq_en_q <= wval[cpw_pkg::IE_BIT] | (irq_en_q & ~wmask[cpw_pkg::IE_BIT]);
         end
         if (wr_value) begin
            duty_low_buffer <= wval[7:0] | (duty_low_buffer & ~wmask[7:0]);
         end
      end
   end

   // The high byte is the compare value's upper half, or the active duty in PWM.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         duty_active_high <= '0;
         duty_latch_q <= '0;
      end else if (is_pwm) begin
         if (period_hit) begin
            {duty_active_high, duty_latch_q} <= duty_next;
         end
      end else if (wr_value) begin
         duty_active_high <= wval[15:8] | (duty_active_high & ~wmask[15:8]);
      end
   end

   // -----------------------------------------------------------------
   // Compare detection and pin
   // -----------------------------------------------------------------
   logic cmp_eq;
   logic cmp_hit;

   assign cmp_eq = timer1_count == {duty_active_high, duty_low_buffer};
   assign cmp_hit = is_cmp && cmp_eq && !cmp_eq_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cmp_eq_q <= 1'b0;
      end else begin
         cmp_eq_q <= cmp_eq;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         shared_output_pin <= 1'b0;
      end else if (wr_mode && mode_new == 6'h00) begin
         shared_output_pin <= 1'b0;
      end else if (is_pwm) begin
         if (period_hit) begin
            shared_output_pin <= duty_next != 10'h000;
         end else if (quarter_end && ext_next == {duty_active_high, duty_latch_q}) begin
            shared_output_pin <= 1'b0;
         end
      end else if (cmp_hit) begin
         if (mode_q == cpw_pkg::MODE_CMP_HIGH) begin
            shared_output_pin <= 1'b1;
         end else if (mode_q == cpw_pkg::MODE_CMP_LOW) begin
            shared_output_pin <= 1'b0;
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         timer1_clear <= 1'b0;
         adc_start <= 1'b0;
      end else begin
         timer1_clear <= cmp_hit && mode_q == cpw_pkg::MODE_CMP_SPECIAL;
         adc_start <= cmp_hit && mode_q == cpw_pkg::MODE_CMP_SPECIAL;
      end
   end

   // -----------------------------------------------------------------
   // Sticky flags and interrupt line
   // -----------------------------------------------------------------
   logic clr_evt;
   logic clr_t2f;

   assign clr_evt = wr_status && wval[cpw_pkg::EVT_BIT];
   assign clr_t2f = wr_status && wval[cpw_pkg::T2F_BIT];

   // A new event in the clearing cycle keeps the flag set.
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_event_flag <= 1'b0;
         t2_flag_q <= 1'b0;
      end else begin
         unit_event_flag <= cmp_hit || (unit_event_flag && !clr_evt);
         t2_flag_q <= (period_hit && post_q == post_sel) || (t2_flag_q && !clr_t2f);
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         unit_irq <= 1'b0;
      end else begin
         unit_irq <= (cmp_hit || unit_event_flag) && irq_en_q;
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite write channels
   // -----------------------------------------------------------------
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_have_q <= 1'b0;
         w_have_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= '0;
         wstrb_q <= '0;
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= cpw_pkg::RESP_OKAY;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_have_q <= 1'b1;
            awaddr_q <= {s_axi_awaddr[7:2], 2'b00};
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_have_q <= 1'b1;
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (wr_en) begin
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? cpw_pkg::RESP_OKAY : cpw_pkg::RESP_SLVERR;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // -----------------------------------------------------------------
   // AXI4-Lite read channels
   // -----------------------------------------------------------------
   logic [31:0] rd_val;
   logic rd_ok;

   always_comb begin
      rd_ok = 1'b1;
      rd_val = '0;
      case ({s_axi_araddr[7:2], 2'b00})
         cpw_pkg::OFF_MODE: rd_val[5:0] = {dlsb_q, mode_q};
         cpw_pkg::OFF_VALUE: rd_val[15:0] = {duty_active_high, duty_low_buffer};
         cpw_pkg::OFF_T2CTRL: rd_val[6:0] = timer2_control;
         cpw_pkg::OFF_PERIOD: rd_val[7:0] = period_register;
         cpw_pkg::OFF_T2CNT: rd_val[7:0] = timer2_count;
         cpw_pkg::OFF_STATUS: rd_val[2:0] = {shared_output_pin, t2_flag_q, unit_event_flag};
         cpw_pkg::OFF_IRQEN: rd_val[cpw_pkg::IE_BIT] = irq_en_q;
         default: rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= '0;
         s_axi_rresp <= cpw_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b1;
         s_axi_rdata <= rd_val;
         s_axi_rresp <= rd_ok ? cpw_pkg::RESP_OKAY : cpw_pkg::RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid <= 1'b0;
         s_axi_arready <= 1'b1;
      end
   end

endmodule

// ===== verification/cpw_unit_props.sv
`timescale 1ns/1ps
module cpw_unit_props (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [7:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic [1:0] s_axi_bresp,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [7:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0] s_axi_rresp,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic [15:0] timer1_count,
   input wire logic shared_output_pin,
   input wire logic timer1_clear,
   input wire logic adc_start,
   input wire logic unit_irq
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   sequence wr_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence rd_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   sequence mode_cleared;
      wr_taken ##0 (s_axi_awaddr[7:2] == 6'h00 && s_axi_wstrb[0] && s_axi_wdata[5:0] == 6'h00);
   endsequence
   pulse_pair_a: assert property (timer1_clear |-> adc_start)
      else $error("timer clear without conversion start");
   pulse_single_a: assert property (timer1_clear |=> !timer1_clear)
      else $error("trigger pulse longer than one cycle");
   trigger_pin_a: assert property (timer1_clear |-> $stable(shared_output_pin))
      else $error("special trigger moved the pin");
   mode_zero_a: assert property (mode_cleared |-> ##[1:4] !shared_output_pin)
      else $error("pin not forced low by zero mode write");
   wr_answer_a: assert property (wr_taken |-> ##[1:2] s_axi_bvalid)
      else $error("write response missing");
   rd_answer_a: assert property (rd_taken |=> s_axi_rvalid)
      else $error("read response missing");
   b_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   r_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read response dropped");
   rd_unmapped_a: assert property (rd_taken ##0 s_axi_araddr[7:2] > 6'h06 |=>
      s_axi_rresp == cpw_pkg::RESP_SLVERR && s_axi_rdata == 32'h0)
      else $error("unmapped read not refused");
endmodule

bind cpw_unit cpw_unit_props props_i (.*);

// ===== verification/cpw_pin_model.sv
`timescale 1ns/1ps
module cpw_pin_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic pin,
   output logic [15:0] period_q,
   output logic [15:0] high_q
);
   logic pin_q;
   logic [15:0] run_q;
   // The load measures cycles between rising edges and the high time of each pulse.
   always_ff @(posedge aclk) begin
      pin_q <= pin;
      if (!aresetn) begin
         run_q <= 16'h0000;
         period_q <= 16'h0000;
      end else if (pin && !pin_q) begin
         period_q <= run_q;
         run_q <= 16'h0001;
      end else begin
         run_q <= run_q + 16'h0001;
      end
   end
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         high_q <= 16'h0000;
      end else if (!pin && pin_q) begin
         high_q <= run_q;
      end
   end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   logic aclk = 0;
   logic aresetn = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0;
   logic s_axi_rready = 0, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid, shared_output_pin, timer1_clear, adc_start, unit_irq;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [15:0] timer1_count = 0, period_q, high_q;
   int n_mismatch = 0, comparisons = 0, pulses = 0;
   always #4 aclk = ~aclk;
   always @(posedge aclk) if (timer1_clear === 1'b1 && adc_start === 1'b1) pulses++;
   cpw_unit dut (.*);
   cpw_pin_model model (.aclk(aclk), .aresetn(aresetn), .pin(shared_output_pin),
      .period_q(period_q), .high_q(high_q));
   task automatic stop_test;
      if (n_mismatch == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic guard(input int i);
      if (i >= 200) begin
         n_mismatch++;
         stop_test();
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'b00);
      int i;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      for (i = 0; i < 200 && s_axi_bvalid !== 1'b1; i++) begin
         @(posedge aclk);
         if (s_axi_awready === 1'b1) s_axi_awvalid <= 0;
         if (s_axi_wready === 1'b1) s_axi_wvalid <= 0;
      end
      guard(i);
      // The response is left waiting one clock so that it must stand.
      s_axi_bready <= 1;
      @(posedge aclk);
      s_axi_bready <= 0;
      check("bresp", s_axi_bresp, er);
   endtask
   task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = 2'b00);
      int i;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      for (i = 0; i < 200 && s_axi_rvalid !== 1'b1; i++) begin
         @(posedge aclk);
         if (s_axi_arready === 1'b1) s_axi_arvalid <= 0;
      end
      guard(i);
      s_axi_rready <= 1;
      @(posedge aclk);
      s_axi_rready <= 0;
      d = s_axi_rdata;
      check("rresp", s_axi_rresp, er);
   endtask
   // Timer1 is driven synchronously, as in timer mode.
   task automatic cmp_case(input logic [3:0] m, input logic ie, input logic ep);
      logic [31:0] r;
      logic p;
      int i;
      wr(cpw_pkg::OFF_IRQEN, 32'(ie));
      wr(cpw_pkg::OFF_MODE, 32'(m));
      pulses = 0;
      timer1_count <= 16'h0001;
      repeat (4) @(posedge aclk);
      check("partial match irq", unit_irq, 0);
      p = shared_output_pin;
      timer1_count <= 16'h8001;
      for (i = 0; i < 8 && unit_irq !== 1'b1 && shared_output_pin === p; i++) @(posedge aclk);
      check("pin", shared_output_pin, ep);
      check("irq", unit_irq, ie);
      repeat (3) @(posedge aclk);
      check("trigger", pulses, m == cpw_pkg::MODE_CMP_SPECIAL);
      rd(cpw_pkg::OFF_STATUS, r);
      check("flag", r[cpw_pkg::EVT_BIT], 1);
      wr(cpw_pkg::OFF_STATUS, 32'h1);
      rd(cpw_pkg::OFF_STATUS, r);
      check("flag clear", r[cpw_pkg::EVT_BIT], 0);
      check("irq clear", unit_irq, 0);
   endtask
   task automatic pwm_case(input logic [6:0] t2, input int div, input logic [7:0] lo,
      input logic [1:0] lsb);
      logic [31:0] r;
      wr(cpw_pkg::OFF_PERIOD, 32'h3);
      wr(cpw_pkg::OFF_VALUE, {16'h0, 8'hff, lo});
      wr(cpw_pkg::OFF_MODE, {26'h0, lsb, 4'h0});
      wr(cpw_pkg::OFF_T2CTRL, {25'h0, t2});
      wr(cpw_pkg::OFF_MODE, {26'h0, lsb, cpw_pkg::MODE_PWM});
      repeat (48 * div + 20) @(posedge aclk);
      check("period", period_q, 16 * div);
      check("high time", high_q, (lo * 4 + lsb) * div);
      rd(cpw_pkg::OFF_VALUE, r);
      check("active duty", r[15:8], lo);
   endtask
   task automatic level_case(input logic [7:0] lo, input logic ep);
      int i;
      int bad;
      wr(cpw_pkg::OFF_T2CTRL, 32'h4);
      wr(cpw_pkg::OFF_MODE, {28'h0, cpw_pkg::MODE_PWM});
      wr(cpw_pkg::OFF_VALUE, {24'h0, lo});
      repeat (60) @(posedge aclk);
      bad = 0;
      for (i = 0; i < 64; i++) begin
         @(posedge aclk);
         if (shared_output_pin !== ep) bad++;
      end
      check("steady pin", bad, 0);
   endtask
   initial begin
      logic [31:0] r;
      repeat (10) @(posedge aclk);
      aresetn <= 1;
      rd(cpw_pkg::OFF_PERIOD, r);
      check("period reset", r, 32'hff);
      rd(cpw_pkg::OFF_MODE, r);
      check("mode reset", r, 32'h0);
      rd(8'h40, r, cpw_pkg::RESP_SLVERR);
      check("unmapped data", r, 32'h0);
      wr(8'h40, 32'h1, cpw_pkg::RESP_SLVERR);
      wr(cpw_pkg::OFF_VALUE, 32'h8001);
      cmp_case(cpw_pkg::MODE_CMP_HIGH, 1, 1);
      cmp_case(cpw_pkg::MODE_CMP_SOFT, 0, 1);
      cmp_case(cpw_pkg::MODE_CMP_LOW, 1, 0);
      cmp_case(cpw_pkg::MODE_CMP_SPECIAL, 1, 0);
      cmp_case(cpw_pkg::MODE_CMP_HIGH, 1, 1);
      wr(cpw_pkg::OFF_MODE, 32'h0);
      repeat (2) @(posedge aclk);
      check("cleared pin", shared_output_pin, 0);
      pwm_case(7'h04, 1, 8'h02, 2'b01);
      pwm_case(7'h05, 4, 8'h02, 2'b01);
      pwm_case(7'h7e, 16, 8'h01, 2'b10);
      level_case(8'hff, 1);
      level_case(8'h00, 0);
      wr(cpw_pkg::OFF_MODE, 32'h0);
      repeat (2) @(posedge aclk);
      check("pwm cleared pin", shared_output_pin, 0);
      stop_test();
   end
endmodule
